// ### sbfug_framer.sv
// Burst framer: preamble, sync words, header and payload blocks, ramp-down.
// Assumes the MAC holds pay_data valid while pay_req is high and drives
// profile and map inputs synchronous to clk.
`timescale 1ns/1ps

// Behaviour
// - Ramp-down follows last block interval
// - Folded ramp optional, disabled by default
// - Multiple-access burst uses one modulation
// - Preamble length comes from burst profile
// - Placement map applies after prescribed delay
// - Payload groups QPSK, then 16, then 64
// - Modulation changes anywhere the map says
// - FEC blocks end at modulation span end
// - Users within a span interleaved together
// - Header fixed size, separately encoded
// - Sync word in every frame
// - In-phase from LFSR, period 2^n-1
// - Quadrature is small nonzero constant
// - Sync lengths 31, 63, 127 supported
// - Mandatory polynomials for 31, 63, 127
// - Optional polynomials and zero length
// - Block interval configured as power total
// - Intervals up to 1024 supported
// - Larger intervals optional extension
// - Pattern begins and ends with sync
// - Preamble is cyclic tail of word
// - Only final payload block may shorten
module sbfug_framer
  import sbfug_pkg::*;
#(
  parameter int                DW          = 16,
  parameter int                PW          = 20,
  parameter logic [EXP_W-1:0]  MAX_EXP     = 4'hA,
  parameter logic              SYNC_OPT_EN = 1'b1,
  parameter logic              FOLD_EN     = 1'b0,
  parameter logic [PW-1:0]     HDR_LEN     = 20'h00040,
  parameter logic signed [7:0] SYNC_AMP    = 8'sh40,
  parameter logic signed [7:0] SYNC_Q      = 8'sh08
)(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [SEL_W-1:0] cfg_sync_sel,
  input  wire logic [EXP_W-1:0] cfg_blk_exp,
  input  wire logic [CNT_W-1:0] cfg_pre_len,
  input  wire logic [CNT_W-1:0] cfg_nblk,
  input  wire logic [CNT_W-1:0] cfg_last_len,
  input  wire logic [7:0]       cfg_ramp_len,
  input  wire logic             cfg_tdma,
  input  wire logic [1:0]       cfg_mod,
  input  wire logic             cfg_fold,
  input  wire logic             map_load,
  input  wire logic [PW-1:0]    map_pos16,
  input  wire logic [PW-1:0]    map_pos64,
  input  wire logic [3:0]       map_delay,
  input  wire logic [DW-1:0]    pay_data,
  output logic                  busy,
  output logic                  pay_req,
  output logic                  sym_valid,
  output logic [2:0]            sym_kind,
  output logic [1:0]            sym_mod,
  output logic signed [7:0]     sym_i,
  output logic signed [7:0]     sym_q,
  output logic [DW-1:0]         sym_data,
  output logic                  fec_end,
  output logic                  burst_done,
  output logic                  cfg_err,
  output logic                  map_err
);

  // ----------------------------------------------------------------
  // State and latched profile
  // ----------------------------------------------------------------
  sbfug_st_e         st_reg, st_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next, mcnt_reg, mcnt_next, blk_reg, blk_next;
  logic [SEL_W-1:0]  sel_reg;
  logic [EXP_W-1:0]  exp_reg;
  logic [CNT_W-1:0]  pre_reg, last_reg;
  logic [7:0]        ramp_reg;
  logic              tdma_reg, fold_reg;
  logic [1:0]        mod_reg;
  logic [PW-1:0]     pidx_reg, pos16_reg, pos64_reg, pend16_reg, pend64_reg;
  logic              pend_vld_reg;
  logic [3:0]        pend_cnt_reg;
  logic              gen_load, gen_step, gen_bit, emit;
  logic              busy_reg, pay_req_reg, sym_valid_reg, fec_end_reg, done_reg, cfg_err_reg, map_err_reg;
  logic [2:0]        kind_reg;
  logic [1:0]        mod_out_reg;
  logic signed [7:0] i_reg, q_reg;
  logic [DW-1:0]     data_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] cfg_u     = sbfug_ulen(cfg_sync_sel);
  wire [CNT_W-1:0] cfg_f     = CNT_W'(1) << cfg_blk_exp;
  wire             sel_ok    = SYNC_OPT_EN || (cfg_sync_sel >= SEL_MAND_LO && cfg_sync_sel <= SEL_MAND_HI);
  // Interval is the power-of-two total; payload span is what remains
  wire             exp_ok    = cfg_blk_exp != '0 && cfg_blk_exp <= MAX_EXP && cfg_f > cfg_u;
  wire             start_ok  = start && st_reg == ST_IDLE && sel_ok && exp_ok && cfg_nblk != '0
                               && (!cfg_tdma || cfg_mod <= MOD_Q64);
  wire [CNT_W-1:0] ulen      = sbfug_ulen(sel_reg);
  wire [CNT_W-1:0] nlen      = (CNT_W'(1) << exp_reg) - ulen;
  wire [CNT_W-1:0] last_eff  = (last_reg == '0 || last_reg > nlen) ? nlen : last_reg;
  wire [CNT_W-1:0] pay_len   = (blk_reg == CNT_W'(1)) ? last_eff : nlen;
  wire [CNT_W-1:0] ramp_w    = CNT_W'(ramp_reg);
  wire             fold_now  = fold_reg && blk_reg == CNT_W'(1) && cnt_reg <= ramp_w;
  wire             take      = st_reg == ST_PAY && !fold_now;
  wire             pay_last  = blk_reg == CNT_W'(1) && cnt_reg == (fold_reg ? ramp_w + CNT_W'(1) : CNT_W'(1));
  wire [PW-1:0]    pidx_nx   = pidx_reg + PW'(1);
  wire             hdr_now   = !tdma_reg && pidx_reg < HDR_LEN;
  wire             hdr_nx    = !tdma_reg && pidx_nx < HDR_LEN;
  // Ordered positions give QPSK, 16, 64 in that order at any symbol
  wire [1:0]       map_now   = pidx_reg >= pos64_reg ? MOD_Q64 : (pidx_reg >= pos16_reg ? MOD_Q16 : MOD_QPSK);
  wire [1:0]       map_nx    = pidx_nx >= pos64_reg ? MOD_Q64 : (pidx_nx >= pos16_reg ? MOD_Q16 : MOD_QPSK);
  wire [1:0]       mod_now   = tdma_reg ? mod_reg : (hdr_now ? MOD_QPSK : map_now);
  wire [1:0]       mod_nx    = tdma_reg ? mod_reg : (hdr_nx ? MOD_QPSK : map_nx);
  // Code blocks close at every span edge; users inside one span share it
  wire             fec_last  = pay_last || hdr_now != hdr_nx || mod_now != mod_nx;
  wire             word_sym  = st_reg == ST_PRE || st_reg == ST_SYNC;
  wire [2:0]       kind_w    = !emit ? KIND_NONE :
                               st_reg == ST_PRE  ? KIND_PRE  :
                               st_reg == ST_SYNC ? KIND_SYNC :
                               (st_reg == ST_RAMP || fold_now) ? KIND_RAMP :
                               hdr_now ? KIND_HDR : KIND_PAY;
  wire             map_bad   = map_load && map_pos16 > map_pos64;
  wire             fold_nx   = fold_reg && blk_next == CNT_W'(1) && cnt_next <= ramp_w;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    mcnt_next = mcnt_reg;
    blk_next  = blk_reg;
    gen_load  = 1'b0;
    gen_step  = 1'b0;
    emit      = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (start_ok) begin
          st_next   = ST_MOD;
          mcnt_next = (cfg_u == '0) ? '0 : cfg_pre_len;
          blk_next  = cfg_nblk;
        end
      end
      ST_MOD: begin
        // Reduce preamble length modulo word length by repeated subtraction
        if (ulen != '0 && mcnt_reg >= ulen) begin
          mcnt_next = mcnt_reg - ulen;
        end else begin
          st_next   = ST_SKIP;
          mcnt_next = (mcnt_reg == '0) ? '0 : ulen - mcnt_reg;
          gen_load  = 1'b1;
        end
      end
      ST_SKIP: begin
        if (mcnt_reg != '0) begin
          gen_step  = 1'b1;
          mcnt_next = mcnt_reg - CNT_W'(1);
        end else begin
          st_next  = ST_PRE;
          cnt_next = pre_reg;
        end
      end
      ST_PRE: begin
        emit = cnt_reg != '0;
        if (cnt_reg <= CNT_W'(1)) begin
          st_next  = ST_SYNC;
          cnt_next = ulen;
          gen_load = 1'b1;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
          gen_step = 1'b1;
        end
      end
      ST_SYNC: begin
        emit     = cnt_reg != '0;
        gen_step = 1'b1;
        if (cnt_reg <= CNT_W'(1)) begin
          if (blk_reg == '0) begin
            // Ramp after the closing word, outside the last interval
            st_next  = (fold_reg || ramp_reg == '0) ? ST_IDLE : ST_RAMP;
            cnt_next = ramp_w;
          end else begin
            st_next  = ST_PAY;
            cnt_next = pay_len;
          end
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      ST_PAY: begin
        emit = 1'b1;
        if (cnt_reg == CNT_W'(1)) begin
          st_next  = ST_SYNC;
          cnt_next = ulen;
          blk_next = blk_reg - CNT_W'(1);
          gen_load = 1'b1;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      ST_RAMP: begin
        emit = 1'b1;
        if (cnt_reg <= CNT_W'(1)) begin
          st_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
    endcase
  end

  sbfug_sync_gen u_gen (
    .clk   (clk),
    .rstn  (rstn),
    .sel   (sel_reg),
    .load  (gen_load),
    .step  (gen_step),
    .bit_o (gen_bit)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg   <= ST_IDLE;
      cnt_reg  <= '0;
      mcnt_reg <= '0;
      blk_reg  <= '0;
      pidx_reg <= '0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      mcnt_reg <= mcnt_next;
      blk_reg  <= blk_next;
      pidx_reg <= start_ok ? '0 : (take ? pidx_nx : pidx_reg);
    end
  end

  // Profile held for the whole burst; inputs may change freely meanwhile
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_reg  <= SEL_MAND_LO;
      exp_reg  <= '0;
      pre_reg  <= '0;
      last_reg <= '0;
      ramp_reg <= '0;
      tdma_reg <= 1'b0;
      mod_reg  <= MOD_QPSK;
      fold_reg <= 1'b0;
    end else if (start_ok) begin
      sel_reg  <= cfg_sync_sel;
      exp_reg  <= cfg_blk_exp;
      pre_reg  <= (cfg_u == '0) ? '0 : cfg_pre_len;
      last_reg <= cfg_last_len;
      ramp_reg <= cfg_ramp_len;
      tdma_reg <= cfg_tdma;
      mod_reg  <= cfg_mod;
      fold_reg <= cfg_fold && FOLD_EN;
    end
  end

  // Map waits a number of burst starts before it steers payload
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_vld_reg <= 1'b0;
      pend_cnt_reg <= '0;
      pend16_reg   <= '0;
      pend64_reg   <= '0;
      pos16_reg    <= '1;
      pos64_reg    <= '1;
      map_err_reg  <= 1'b0;
    end else begin
      map_err_reg <= map_bad;
      if (map_load && !map_bad) begin
        pend_vld_reg <= 1'b1;
        pend_cnt_reg <= map_delay;
        pend16_reg   <= map_pos16;
        pend64_reg   <= map_pos64;
      end else if (start_ok && pend_vld_reg) begin
        if (pend_cnt_reg == '0) begin
          pend_vld_reg <= 1'b0;
          pos16_reg    <= pend16_reg;
          pos64_reg    <= pend64_reg;
        end else begin
          pend_cnt_reg <= pend_cnt_reg - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_reg      <= 1'b0;
      pay_req_reg   <= 1'b0;
      sym_valid_reg <= 1'b0;
      kind_reg      <= KIND_NONE;
      mod_out_reg   <= MOD_QPSK;
      i_reg         <= '0;
      q_reg         <= '0;
      data_reg      <= '0;
      fec_end_reg   <= 1'b0;
      done_reg      <= 1'b0;
      cfg_err_reg   <= 1'b0;
    end else begin
      busy_reg      <= st_next != ST_IDLE;
      pay_req_reg   <= st_next == ST_PAY && !fold_nx;
      sym_valid_reg <= emit;
      kind_reg      <= kind_w;
      mod_out_reg   <= take ? mod_now : MOD_QPSK;
      i_reg         <= (emit && word_sym) ? (gen_bit ? SYNC_AMP : -SYNC_AMP) : 8'sh00;
      q_reg         <= (emit && word_sym) ? SYNC_Q : 8'sh00;
      data_reg      <= take ? pay_data : '0;
      fec_end_reg   <= take && fec_last;
      done_reg      <= st_reg != ST_IDLE && st_next == ST_IDLE;
      cfg_err_reg   <= start && !start_ok;
    end
  end

  assign busy       = busy_reg;
  assign pay_req    = pay_req_reg;
  assign sym_valid  = sym_valid_reg;
  assign sym_kind   = kind_reg;
  assign sym_mod    = mod_out_reg;
  assign sym_i      = i_reg;
  assign sym_q      = q_reg;
  assign sym_data   = data_reg;
  assign fec_end    = fec_end_reg;
  assign burst_done = done_reg;
  assign cfg_err    = cfg_err_reg;
  assign map_err    = map_err_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [CNT_W-1:0] run_reg;
  logic [1:0]       last_mod_reg;
  logic [2:0]       pspan_reg;
  logic             pspan_vld_reg, last_fec_reg;
  wire              out_pay  = sym_valid && (sym_kind == KIND_PAY || sym_kind == KIND_HDR);
  wire [2:0]        out_span = {sym_kind == KIND_HDR, sym_mod};

  always_ff @(posedge clk) begin
    if (!rstn || start_ok) begin
      run_reg       <= '0;
      last_mod_reg  <= MOD_QPSK;
      pspan_reg     <= '0;
      pspan_vld_reg <= 1'b0;
      last_fec_reg  <= 1'b0;
    end else begin
      run_reg <= (sym_valid && sym_kind == KIND_SYNC) ? run_reg + CNT_W'(1) : '0;
      if (out_pay) begin
        last_mod_reg  <= sym_mod;
        pspan_reg     <= out_span;
        pspan_vld_reg <= 1'b1;
        last_fec_reg  <= fec_end;
      end
    end
  end

  sequence s_word_end;
    run_reg != '0 ##0 !(sym_valid && sym_kind == KIND_SYNC);
  endsequence
  property p_word_len;
    s_word_end |-> run_reg == ulen;
  endproperty
  a_word_len: assert property (p_word_len) else $error("sync word length wrong");

  property p_q_const;
    sym_valid && (sym_kind == KIND_SYNC || sym_kind == KIND_PRE) |-> sym_q == SYNC_Q && sym_q != 8'sh00;
  endproperty
  a_q_const: assert property (p_q_const) else $error("quadrature level wrong");

  property p_ramp_after_word;
    sym_valid && sym_kind == KIND_RAMP && !fold_reg && $past(sym_kind) != KIND_RAMP && ulen != '0
      |-> $past(sym_kind) == KIND_SYNC;
  endproperty
  a_ramp_after_word: assert property (p_ramp_after_word) else $error("ramp not after closing word");

  property p_fold_off;
    busy && !FOLD_EN |-> !fold_reg && sym_kind != KIND_RAMP || st_reg == ST_RAMP || $past(st_reg) == ST_RAMP;
  endproperty
  a_fold_off: assert property (p_fold_off) else $error("folded ramp while disabled");

  property p_tdma_one_mod;
    out_pay && tdma_reg |-> sym_mod == mod_reg;
  endproperty
  a_tdma_one_mod: assert property (p_tdma_one_mod) else $error("modulation changed in burst");

  property p_rising_mod;
    out_pay |-> sym_mod >= last_mod_reg;
  endproperty
  a_rising_mod: assert property (p_rising_mod) else $error("robustness order broken");

  property p_fec_span;
    out_pay && pspan_vld_reg && out_span != pspan_reg |-> last_fec_reg;
  endproperty
  a_fec_span: assert property (p_fec_span) else $error("code block crosses span");

  property p_cfg_hold;
    busy && $past(busy) |-> $stable(sel_reg) && $stable(exp_reg) && $stable(pre_reg) && $stable(mod_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("profile changed in burst");

  property p_end_word;
    burst_done && ulen != '0 && ramp_reg == '0 |-> sym_kind == KIND_SYNC;
  endproperty
  a_end_word: assert property (p_end_word) else $error("burst not closed by word");

endmodule // sbfug_framer

// ### sbfug_framer_bench.sv
// Bench for the burst framer: a table of bursts checked against a queue model.
// Assumes framer defaults: no fold, 64-symbol header, 0x40 and 0x08 levels.
`timescale 1ns/1ps
module sbfug_framer_bench
  import sbfug_pkg::*;
;
  typedef struct {logic [2:0] k; logic signed [7:0] i; logic [1:0] m; logic [15:0] d; logic f;} sbfug_sym_s;
  logic              clk = 0, rstn = 0, start = 0, cfg_tdma = 0, cfg_fold = 0, map_load = 0;
  logic [SEL_W-1:0]  cfg_sync_sel = '0;
  logic [EXP_W-1:0]  cfg_blk_exp = '0;
  logic [CNT_W-1:0]  cfg_pre_len = '0, cfg_nblk = '0, cfg_last_len = '0;
  logic [7:0]        cfg_ramp_len = '0;
  logic [1:0]        cfg_mod = '0, sym_mod;
  logic [19:0]       map_pos16 = '0, map_pos64 = '0;
  logic [3:0]        map_delay = '0;
  logic [15:0]       pay_data = '0, rnd = 16'h002D, sym_data;
  logic              busy, pay_req, sym_valid, fec_end, burst_done, cfg_err, map_err, done;
  logic [2:0]        sym_kind;
  logic signed [7:0] sym_i, sym_q;
  logic [9:0]        poly [8] = '{10'h000, 10'h00B, 10'h013, 10'h025, 10'h043, 10'h083, 10'h11D, 10'h211};
  int                fails, checks, sync_cnt, q_bad, pend, pcnt, m16, m64;
  int                ap16 = 20'hFFFFF, ap64 = 20'hFFFFF;
  sbfug_sym_s        rec[$];
  int                pq[$], sb[$], pb[$];

  always #12.5 clk = ~clk;

  sbfug_framer sbfug_framer_inst (.clk, .rstn, .start, .cfg_sync_sel, .cfg_blk_exp, .cfg_pre_len, .cfg_nblk,
    .cfg_last_len, .cfg_ramp_len, .cfg_tdma, .cfg_mod, .cfg_fold, .map_load, .map_pos16, .map_pos64,
    .map_delay, .pay_data, .busy, .pay_req, .sym_valid, .sym_kind, .sym_mod, .sym_i, .sym_q, .sym_data,
    .fec_end, .burst_done, .cfg_err, .map_err);
  sbfug_rx_model sbfug_rx_model_inst (.clk, .rstn, .sym_valid, .sym_kind, .sym_q, .sync_cnt, .q_bad);

  // ----------------------------------------------------------------
  // Model and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int mof(input int x);
    return (x < 64 || x < ap16) ? 0 : (x < ap64) ? 1 : 2;
  endfunction

  // Either shift direction is fine, so accept the polynomial or its reverse
  function automatic int recur(input int u, input int dg, input int p, input int rv);
    int x;
    for (int k = 0; k < u; k++) begin
      x = 0;
      for (int j = 0; j <= dg; j++) if (p[j]) x ^= sb[(k + (rv ? dg - j : j)) % u];
      if (x) return 0;
    end
    return 1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(negedge clk) begin
    rnd = lf(rnd);
    pay_data = rnd;
    if (pay_req === 1'b1) pq.push_back(pay_data);
    if (sym_valid === 1'b1) rec.push_back('{sym_kind, sym_i, sym_mod, sym_data, fec_end});
    if (burst_done === 1'b1) done = 1;
  end

  task automatic mapld(input int p16, input int p64, input int d);
    map_pos16 = p16[19:0];
    map_pos64 = p64[19:0];
    map_delay = d[3:0];
    map_load = 1;
    @(negedge clk) map_load = 0;
    chk(map_err, p16 > p64);
    if (p16 <= p64) begin
      pend = 1;
      pcnt = d;
      m16 = p16;
      m64 = p64;
    end
    @(negedge clk);
  endtask

  task automatic burst(input int s, input int e, input int a, input int nb, input int l, input int r,
                       input int t, input int m);
    int u, n, nl, pl, c0, idx;
    int ek[$];
    u = s ? (1 << (s + 2)) - 1 : 0;
    n = (1 << e) - u;
    nl = (l == 0 || l > n) ? n : l;
    pl = (nb - 1) * n + nl;
    if (pend && pcnt == 0) begin
      ap16 = m16;
      ap64 = m64;
      pend = 0;
    end else if (pend) pcnt--;
    rec.delete();
    pq.delete();
    sb.delete();
    pb.delete();
    done = 0;
    c0 = sync_cnt;
    {cfg_sync_sel, cfg_blk_exp, cfg_pre_len, cfg_nblk, cfg_last_len} = {s[2:0], e[3:0], a[13:0], nb[13:0], l[13:0]};
    {cfg_ramp_len, cfg_tdma, cfg_mod, cfg_fold} = {r[7:0], t[0], m[1:0], rnd[0]};
    start = 1;
    @(negedge clk) start = 0;
    chk(busy, 1);
    // Profile inputs wander mid-burst; the burst must not follow them
    {cfg_sync_sel, cfg_blk_exp, cfg_pre_len, cfg_mod, cfg_tdma} = {rnd[7:0], rnd};
    @(negedge clk) start = 1;
    @(negedge clk) start = 0;
    chk(cfg_err, 1);
    for (int k = 0; k < 20000 && !done; k++) @(negedge clk);
    // Far end counts the closing word one edge later
    @(negedge clk);
    repeat (u ? a : 0) ek.push_back(1);
    for (int b = 0; b <= nb; b++) begin
      repeat (u) ek.push_back(2);
      if (b < nb) repeat (b == nb - 1 ? nl : n) ek.push_back(4);
    end
    repeat (r) ek.push_back(5);
    chk(rec.size(), ek.size());
    idx = 0;
    foreach (rec[j]) if (j < ek.size()) begin
      if (ek[j] == 4) begin
        chk(rec[j].k, (!t && idx < 64) ? 3 : 4);
        chk(rec[j].m, t ? m : mof(idx));
        chk(rec[j].d, pq[idx]);
        chk(rec[j].f, idx == pl - 1 || (!t && (idx == 63 || mof(idx) != mof(idx + 1))));
        idx++;
      end else begin
        chk(rec[j].k, ek[j]);
        if (ek[j] == 5) chk(rec[j].i, 0);
        else begin
          chk(rec[j].i == 64 || rec[j].i == -64, 1);
          if (ek[j] == 1) pb.push_back(rec[j].i > 0);
          else sb.push_back(rec[j].i > 0);
        end
      end
    end
    chk(sync_cnt - c0, (nb + 1) * u);
    chk(q_bad, 0);
    if (u) chk(sb[0], 1);
    foreach (sb[k]) chk(sb[k], sb[k % u]);
    foreach (pb[k]) chk(pb[k], sb[(u - a % u + k) % u]);
    chk(recur(u, s + 2, poly[s], 0) || recur(u, s + 2, poly[s], 1), 1);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    repeat (5) @(negedge clk);
    rstn = 1;
    for (int k = 0; k < 3; k++) begin
      cfg_sync_sel = k == 2 ? 3'h5 : 3'h3;
      cfg_blk_exp = k == 0 ? 4'h0 : k == 1 ? 4'hB : 4'h6;
      cfg_nblk = 14'h0001;
      start = 1;
      @(negedge clk) start = 0;
      chk(cfg_err, 1);
      chk(busy, 0);
      @(negedge clk);
    end
    mapld(200, 100, 0);
    mapld(70, 150, 1);
    burst(3, 6, 10, 3, 0, 4, 1, 2);
    burst(4, 7, 70, 2, 20, 3, 0, 0);
    burst(3, 7, 0, 2, 0, 2, 0, 0);
    burst(5, 8, 127, 1, 5, 1, 1, 0);
    burst(1, 4, 3, 4, 200, 2, 1, 1);
    burst(2, 5, 20, 2, 0, 1, 1, 1);
    burst(6, 9, 5, 1, 0, 1, 1, 2);
    burst(7, 10, 0, 1, 9, 1, 1, 0);
    burst(0, 5, 9, 2, 7, 2, 0, 0);
    burst(3, 5, 0, 1, 0, 0, 1, 1);
    summarize();
  end
endmodule // sbfug_framer_bench

// ### sbfug_pkg.sv
// Shared constants for the burst framer and its sync word generator.
// Assumes one symbol clock; SEL_W is used by both design files, the other widths by one each.
package sbfug_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 14;
  localparam int LFSR_W = 9;
  localparam int SEL_W  = 3;
  localparam int EXP_W  = 4;

  // ----------------------------------------------------------------
  // Sync word generator tables, indexed by length select
  // ----------------------------------------------------------------
  // Lengths 0, 7, 15, 31, 63, 127, 255, 511; length is 2**deg - 1
  localparam logic [9:0] SYNC_POLY [8] = '{10'h000, 10'h00B, 10'h013, 10'h025,
                                          10'h043, 10'h083, 10'h11D, 10'h211};
  localparam logic [3:0] SYNC_DEG  [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  localparam logic [SEL_W-1:0] SEL_MAND_LO = 3'h3;
  localparam logic [SEL_W-1:0] SEL_MAND_HI = 3'h5;

  // ----------------------------------------------------------------
  // Symbol kinds and modulation codes
  // ----------------------------------------------------------------
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_PRE  = 3'h1;
  localparam logic [2:0] KIND_SYNC = 3'h2;
  localparam logic [2:0] KIND_HDR  = 3'h3;
  localparam logic [2:0] KIND_PAY  = 3'h4;
  localparam logic [2:0] KIND_RAMP = 3'h5;

  localparam logic [1:0] MOD_QPSK = 2'h0;
  localparam logic [1:0] MOD_Q16  = 2'h1;
  localparam logic [1:0] MOD_Q64  = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_MOD, ST_SKIP, ST_PRE, ST_SYNC, ST_PAY, ST_RAMP} sbfug_st_e;

  function automatic logic [CNT_W-1:0] sbfug_ulen(input logic [SEL_W-1:0] sel);
    logic [CNT_W:0] top;
    top = (CNT_W+1)'(1) << SYNC_DEG[sel];
    return CNT_W'(top - (CNT_W+1)'(1));
  endfunction

endpackage

// ### sbfug_rx_model.sv
// Far-end receiver model: listens to the framer symbols and tallies sync symbols.
// Assumes the symbol outputs are registered on the rising edge of clk.
`timescale 1ns/1ps
module sbfug_rx_model
  import sbfug_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              sym_valid,
  input  wire logic [2:0]        sym_kind,
  input  wire logic signed [7:0] sym_q,
  output int                     sync_cnt,
  output int                     q_bad
);
  // Receive only, so it never drives anything back to the framer
  always @(posedge clk) begin
    if (!rstn) begin
      sync_cnt <= 0;
      q_bad    <= 0;
    end else if (sym_valid === 1'b1 && sym_kind === KIND_SYNC) begin
      sync_cnt <= sync_cnt + 1;
      if (sym_q !== 8'sh08) q_bad <= q_bad + 1;
    end
  end
endmodule // sbfug_rx_model

// ### sbfug_sync_gen.sv
// Sync word in-phase bit generator: selectable maximal-length shift register.
// Assumes the caller loads it at each word start and steps once per symbol.
`timescale 1ns/1ps
module sbfug_sync_gen
  import sbfug_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             load,
  input  wire logic             step,
  output logic                  bit_o
);

  // ----------------------------------------------------------------
  // Feedback
  // ----------------------------------------------------------------
  logic [LFSR_W-1:0] sr_reg;
  logic [LFSR_W-1:0] sr_next;
  logic [3:0]        deg;
  logic [LFSR_W:0]   top;
  logic [LFSR_W-1:0] ones;
  logic [LFSR_W-1:0] taps;
  logic              fb;
  logic [LFSR_W-1:0] shifted;

  assign deg     = SYNC_DEG[sel];
  assign top     = (LFSR_W+1)'(1) << deg;
  assign ones    = LFSR_W'(top - (LFSR_W+1)'(1));
  assign taps    = SYNC_POLY[sel][LFSR_W-1:0] & ones;
  assign fb      = ^(sr_reg & taps);
  assign shifted = (sr_reg >> 1) | (LFSR_W'(fb) << (deg - 4'h1));
  // Load wins so a word always restarts from all ones
  assign sr_next = load ? ones : (step ? shifted : sr_reg);
  assign bit_o   = sr_reg[0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sr_reg <= '1;
    end else begin
      sr_reg <= sr_next;
    end
  end

endmodule // sbfug_sync_gen
